// File: src/general_timer_counter_channel.sv
`timescale 1ns/1ps
`include "general_timer_counter_map.svh"
// One timer/counter set running on the core clock.
module general_timer_counter_channel (
  // Clock and reset.
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic              clk_en,
  // Software control.
  input  wire general_timer_counter_pkg::general_timer_counter_cfg_t cfg,
  input  wire logic              sw_start,
  input  wire logic              sw_reset,
  input  wire logic              int_tick,
  // Synchronised pins.
  input  wire general_timer_counter_pkg::general_timer_counter_pins_t pins,
  // Results.
  output logic                   pulse_out,
  output general_timer_counter_pkg::general_timer_counter_stat_t   stat
);
  typedef enum logic [2:0] {
    GENERAL_TIMER_COUNTER_IDLE, GENERAL_TIMER_COUNTER_ARMED, GENERAL_TIMER_COUNTER_RUN, GENERAL_TIMER_COUNTER_DELAY, GENERAL_TIMER_COUNTER_PULSE, GENERAL_TIMER_COUNTER_DONE
  } general_timer_counter_state_t;

  general_timer_counter_state_t state_r;
  general_timer_counter_state_t state_nxt;
  logic [31:0] count_r;
  logic [31:0] count_nxt;
  logic [31:0] phase_r;
  logic [31:0] phase_nxt;
  logic        out_r;
  logic        out_nxt;
  logic        clk_prev_r;
  logic        gate_prev_r;

  // Polarity is folded in first so the modes see active-high signals.
  wire clk_lvl  = pins.clk ^ cfg.clk_pol_low;        // [R5]
  wire gate_act = pins.gate ^ cfg.gate_pol_low;      // [R5]
  wire ext_edge = clk_lvl & ~clk_prev_r;
  wire gate_rise = gate_act & ~gate_prev_r;
  wire gate_fall = ~gate_act & gate_prev_r;
  wire step     = cfg.ext_clk_sel ? ext_edge : int_tick; // [R2]
  wire dir_up   = cfg.sw_dir_sel ? cfg.sw_dir_up : pins.dir; // [R4]
  wire [31:0] count_step = dir_up ? count_r + `GENERAL_TIMER_COUNTER_CNT_ONE
                                  : count_r - `GENERAL_TIMER_COUNTER_CNT_ONE; // [R3] [R1]
  wire is_gated = (cfg.mode == `GENERAL_TIMER_COUNTER_MODE_GATED) |
                  (cfg.mode == `GENERAL_TIMER_COUNTER_MODE_SGL) |
                  (cfg.mode == `GENERAL_TIMER_COUNTER_MODE_CONT);
  wire is_trig  = (cfg.mode == `GENERAL_TIMER_COUNTER_MODE_TRIG) |
                  (cfg.mode == `GENERAL_TIMER_COUNTER_MODE_RETRIG) |
                  (cfg.mode == `GENERAL_TIMER_COUNTER_MODE_TCONT);
  wire is_cont  = (cfg.mode == `GENERAL_TIMER_COUNTER_MODE_TCONT) |
                  (cfg.mode == `GENERAL_TIMER_COUNTER_MODE_CONT);
  wire run_ok   = ~is_gated | gate_act;               // [R13] [R17]
  wire [31:0] phase_dec = phase_r - `GENERAL_TIMER_COUNTER_CNT_ONE;
  wire phase_last = (phase_r <= `GENERAL_TIMER_COUNTER_CNT_ONE);

  // Mode sequencing; the pulse modes use phase_r for delay and width.
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    phase_nxt = phase_r;
    out_nxt   = out_r;
    if (sw_reset) begin                               // [R9]
      state_nxt = GENERAL_TIMER_COUNTER_IDLE;
      count_nxt = cfg.init_count;
      phase_nxt = `GENERAL_TIMER_COUNTER_CNT_ZERO;
      out_nxt   = 1'b0;
    end else if (sw_start) begin                      // [R8] [R6]
      count_nxt = cfg.init_count;
      out_nxt   = 1'b0;
      phase_nxt = cfg.pulse_delay;
      if (cfg.mode == `GENERAL_TIMER_COUNTER_MODE_GATED)
        state_nxt = GENERAL_TIMER_COUNTER_RUN;
      else if (is_trig || cfg.mode == `GENERAL_TIMER_COUNTER_MODE_PERIOD ||
               cfg.mode == `GENERAL_TIMER_COUNTER_MODE_WIDTH)
        state_nxt = GENERAL_TIMER_COUNTER_ARMED;
      else if (cfg.mode == `GENERAL_TIMER_COUNTER_MODE_SGL || cfg.mode == `GENERAL_TIMER_COUNTER_MODE_CONT)
        state_nxt = GENERAL_TIMER_COUNTER_DELAY;
      else
        state_nxt = GENERAL_TIMER_COUNTER_IDLE;
    end else begin
      unique case (state_r)
        GENERAL_TIMER_COUNTER_IDLE: ;                                  // [R8]
        GENERAL_TIMER_COUNTER_ARMED: begin
          if (cfg.mode == `GENERAL_TIMER_COUNTER_MODE_WIDTH && gate_act) begin
            state_nxt = GENERAL_TIMER_COUNTER_RUN;                     // [R12]
            if (step) count_nxt = count_step;
          end else if (gate_rise) begin
            state_nxt = (cfg.mode == `GENERAL_TIMER_COUNTER_MODE_PERIOD) ? GENERAL_TIMER_COUNTER_RUN
                                                        : GENERAL_TIMER_COUNTER_DELAY;
            phase_nxt = cfg.pulse_delay;              // [R14] [R15] [R16]
          end
        end
        GENERAL_TIMER_COUNTER_RUN: begin
          if (cfg.mode == `GENERAL_TIMER_COUNTER_MODE_GATED) begin
            if (step && gate_act) count_nxt = count_step; // [R10]
          end else if (cfg.mode == `GENERAL_TIMER_COUNTER_MODE_PERIOD && gate_rise) begin
            state_nxt = GENERAL_TIMER_COUNTER_DONE;                    // [R11]
            out_nxt   = 1'b1;
          end else if (cfg.mode == `GENERAL_TIMER_COUNTER_MODE_WIDTH && gate_fall) begin
            state_nxt = GENERAL_TIMER_COUNTER_DONE;                    // [R12]
            out_nxt   = 1'b1;
          end else if (step) begin
            count_nxt = count_step;                   // [R11] [R12]
          end
        end
        GENERAL_TIMER_COUNTER_DELAY: begin
          if (step && run_ok) begin
            count_nxt = count_step;
            phase_nxt = phase_dec;
            if (phase_last) begin
              state_nxt = GENERAL_TIMER_COUNTER_PULSE;
              phase_nxt = cfg.pulse_width;
              out_nxt   = 1'b1;
            end
          end
        end
        GENERAL_TIMER_COUNTER_PULSE: begin
          if (step && run_ok) begin
            count_nxt = count_step;
            phase_nxt = phase_dec;
            if (phase_last) begin
              out_nxt = 1'b0;
              if (is_cont) begin                      // [R16] [R17]
                state_nxt = GENERAL_TIMER_COUNTER_DELAY;
                phase_nxt = cfg.pulse_delay;
              end else if (cfg.mode == `GENERAL_TIMER_COUNTER_MODE_RETRIG)
                state_nxt = GENERAL_TIMER_COUNTER_ARMED;               // [R15]
              else
                state_nxt = GENERAL_TIMER_COUNTER_IDLE;                // [R13] [R14]
            end
          end
        end
        GENERAL_TIMER_COUNTER_DONE: ;                                  // [R18]
        default: state_nxt = GENERAL_TIMER_COUNTER_IDLE;
      endcase
    end
  end

  // State registers; all frozen while the clock enable is low.
  always_ff @(posedge clock) begin
    if (srst) begin
      state_r     <= GENERAL_TIMER_COUNTER_IDLE;
      count_r     <= `GENERAL_TIMER_COUNTER_CNT_ZERO;
      phase_r     <= `GENERAL_TIMER_COUNTER_CNT_ZERO;
      out_r       <= 1'b0;
      clk_prev_r  <= 1'b0;
      gate_prev_r <= 1'b0;
      pulse_out   <= 1'b0;
      stat        <= '0;
    end else if (clk_en) begin
      state_r     <= state_nxt;
      count_r     <= count_nxt;
      phase_r     <= phase_nxt;
      out_r       <= out_nxt;
      clk_prev_r  <= clk_lvl;
      gate_prev_r <= gate_act;
      pulse_out   <= out_nxt ^ cfg.out_pol_low;       // [R5]
      stat.count  <= count_nxt;                       // [R7]
      stat.done   <= (state_nxt == GENERAL_TIMER_COUNTER_DONE);
      stat.running <= (state_nxt != GENERAL_TIMER_COUNTER_IDLE) && (state_nxt != GENERAL_TIMER_COUNTER_DONE);
    end
  end
endmodule // general_timer_counter_channel

// File: src/general_timer_counter_map.svh
// Summary of operation
// R1 - Each counter holds a 32-bit count; three sets are provided.
// R2 - Counting clock selects internal timebase or synchronised external pin.
// R3 - Every active clock edge steps the count by one, up or down.
// R4 - Direction high counts up, low counts down; pin or software source.
// R5 - Clock edge, gate and output polarities are software programmable.
// R6 - Software writes an initial count that is loaded as starting value.
// R7 - Current count is readable at any time without disturbing operation.
// R8 - No mode operates until software-start; before that the counter idles.
// R9 - Software reset clears status, reloads initial value, halts until start.
// R10 - Mode 1 counts clock edges while gate active, holds otherwise.
// R11 - Mode 2 counts edges between two gate edges, then output high.
// R12 - Mode 3 counts edges while gate active, output high at pulse end.
// R13 - Mode 4 emits one delayed pulse after start, pausing while gate inactive.
// R14 - Mode 5 first gate edge triggers one pulse; later edges ignored.
// R15 - Mode 6 every gate edge triggers a pulse; edges during pulse ignored.
// R16 - Mode 7 first gate edge starts continuous pulses; later edges ignored.
// R17 - Mode 8 periodic pulses from start, halted while gate inactive.
// R18 - After mode 2 or 3 completes, output stays high and count frozen.
`ifndef GENERAL_TIMER_COUNTER_MAP_SVH
`define GENERAL_TIMER_COUNTER_MAP_SVH
`define GENERAL_TIMER_COUNTER_CNT_W      32
`define GENERAL_TIMER_COUNTER_NUM_SETS   3
`define GENERAL_TIMER_COUNTER_CNT_ZERO   32'h0000_0000
`define GENERAL_TIMER_COUNTER_CNT_ONE    32'h0000_0001
`define GENERAL_TIMER_COUNTER_MODE_W     4
`define GENERAL_TIMER_COUNTER_MODE_GATED 4'h1
`define GENERAL_TIMER_COUNTER_MODE_PERIOD 4'h2
`define GENERAL_TIMER_COUNTER_MODE_WIDTH 4'h3
`define GENERAL_TIMER_COUNTER_MODE_SGL   4'h4
`define GENERAL_TIMER_COUNTER_MODE_TRIG  4'h5
`define GENERAL_TIMER_COUNTER_MODE_RETRIG 4'h6
`define GENERAL_TIMER_COUNTER_MODE_TCONT 4'h7
`define GENERAL_TIMER_COUNTER_MODE_CONT  4'h8
`define GENERAL_TIMER_COUNTER_INT_CLK_MHZ 80
`define GENERAL_TIMER_COUNTER_EXT_CLK_MHZ 10
`endif

// File: src/general_timer_counter_pkg.sv
package general_timer_counter_pkg;
  // Software configuration of one counter set.
  typedef struct packed {
    logic [3:0]  mode;
    logic        ext_clk_sel;
    logic        sw_dir_sel;
    logic        sw_dir_up;
    logic        clk_pol_low;
    logic        gate_pol_low;
    logic        out_pol_low;
    logic [31:0] init_count;
    logic [31:0] pulse_delay;
    logic [31:0] pulse_width;
  } general_timer_counter_cfg_t;

  // Pins of one counter set, already in the core clock domain.
  typedef struct packed {
    logic clk;
    logic gate;
    logic dir;
  } general_timer_counter_pins_t;

  // Status shown to software.
  typedef struct packed {
    logic        running;
    logic        done;
    logic [31:0] count;
  } general_timer_counter_stat_t;
endpackage

// File: src/general_timer_counter_top.sv
`timescale 1ns/1ps
`include "general_timer_counter_map.svh"
// Three general timer/counter sets sharing one internal timebase.
module general_timer_counter_top (
  // Clock, reset and enable.
  input  wire logic                 clock,
  input  wire logic                 srst,
  input  wire logic                 clk_en,
  // Software control, one entry per set.
  input  wire general_timer_counter_pkg::general_timer_counter_cfg_t  cfg [`GENERAL_TIMER_COUNTER_NUM_SETS],
  input  wire logic [2:0]           sw_start,
  input  wire logic [2:0]           sw_reset,
  // Counter pins, asynchronous to the core clock.
  input  wire logic [2:0]           tc_clock_in,
  input  wire logic [2:0]           tc_gate_in,
  input  wire logic [2:0]           tc_direction_in,
  // Results.
  output logic [2:0]                tc_pulse_out,
  output general_timer_counter_pkg::general_timer_counter_stat_t      stat [`GENERAL_TIMER_COUNTER_NUM_SETS]
);
  logic [2:0] sync1_clk_r;
  logic [2:0] sync2_clk_r;
  logic [2:0] sync1_gate_r;
  logic [2:0] sync2_gate_r;
  logic [2:0] sync1_dir_r;
  logic [2:0] sync2_dir_r;

  // Two-stage synchronisers; external clocks are sampled, so the
  // external rate must stay well below half the core clock.
  always_ff @(posedge clock) begin
    if (srst) begin
      sync1_clk_r  <= 3'h0;
      sync2_clk_r  <= 3'h0;
      sync1_gate_r <= 3'h0;
      sync2_gate_r <= 3'h0;
      sync1_dir_r  <= 3'h0;
      sync2_dir_r  <= 3'h0;
    end else if (clk_en) begin
      sync1_clk_r  <= tc_clock_in;
      sync2_clk_r  <= sync1_clk_r;                    // [R2]
      sync1_gate_r <= tc_gate_in;
      sync2_gate_r <= sync1_gate_r;
      sync1_dir_r  <= tc_direction_in;
      sync2_dir_r  <= sync1_dir_r;
    end
  end

  // One counter set per instance.
  for (genvar i = 0; i < `GENERAL_TIMER_COUNTER_NUM_SETS; i++) begin : g_set // [R1]
    general_timer_counter_pkg::general_timer_counter_pins_t pins_w;
    assign pins_w = '{clk: sync2_clk_r[i], gate: sync2_gate_r[i],
                      dir: sync2_dir_r[i]};
    general_timer_counter_channel u_channel (
      .clock    (clock),
      .srst     (srst),
      .clk_en   (clk_en),
      .cfg      (cfg[i]),
      .sw_start (sw_start[i]),
      .sw_reset (sw_reset[i]),
      .int_tick (1'b1),
      .pins     (pins_w),
      .pulse_out(tc_pulse_out[i]),
      .stat     (stat[i])
    );
  end
endmodule // general_timer_counter_top

// File: bench/general_timer_counter_chk_sva.sv
`timescale 1ns/1ps
`include "general_timer_counter_map.svh"
// Watches set 0; the other two sets are copies of the same logic.
module general_timer_counter_chk (
  // Clock and reset.
  input wire logic                 clock,
  input wire logic                 srst,
  input wire logic                 clk_en,
  // Control and pins.
  input wire general_timer_counter_pkg::general_timer_counter_cfg_t  cfg [`GENERAL_TIMER_COUNTER_NUM_SETS],
  input wire logic [2:0]           sw_start,
  input wire logic [2:0]           sw_reset,
  input wire logic [2:0]           tc_gate_in,
  // Results.
  input wire logic [2:0]           tc_pulse_out,
  input wire general_timer_counter_pkg::general_timer_counter_stat_t stat [`GENERAL_TIMER_COUNTER_NUM_SETS]
);
  // Active levels after polarity, and a cycle with no software request.
  wire logic quiet = clk_en && !sw_start[0] && !sw_reset[0];
  wire logic g_on  = tc_gate_in[0] ^ cfg[0].gate_pol_low;
  wire logic o_on  = tc_pulse_out[0] ^ cfg[0].out_pol_low;
  wire logic m1    = cfg[0].mode == 4'h1 && stat[0].running;
  logic [4:0] g_hist_r;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Gate history covers the synchroniser delay before a level counts.
  always_ff @(posedge clock) g_hist_r <= {g_hist_r[3:0], g_on};

  AST_START_LOAD: assert property (sw_start[0] && !sw_reset[0] && clk_en
    |=> stat[0].count == $past(cfg[0].init_count)
    && (cfg[0].mode != 4'h1 || stat[0].running)) else $error("start load");
  AST_RESET_CLEAR: assert property (sw_reset[0] && clk_en |=>
    stat[0].count == $past(cfg[0].init_count) && !stat[0].running
    && !stat[0].done) else $error("reset clear");
  AST_IDLE_HOLD: assert property (!stat[0].running && quiet
    && $stable(cfg[0]) |=> $stable(stat[0].count)) else $error("idle move");
  AST_GATE_HOLD: assert property (m1 && quiet && !g_on
    && g_hist_r == 5'h00 |=> $stable(stat[0].count)) else $error("gate hold");
  AST_STEP: assert property (m1 && quiet && !cfg[0].ext_clk_sel
    && cfg[0].sw_dir_sel && g_on && g_hist_r == 5'h1F && $stable(cfg[0])
    |=> stat[0].count == $past(stat[0].count) + ($past(cfg[0].sw_dir_up)
    ? 32'h0000_0001 : 32'hFFFF_FFFF)) else $error("step wrong");
  AST_DONE_HOLD: assert property (stat[0].done && quiet
    && $stable(cfg[0]) |=> stat[0].done && $stable(stat[0].count)
    && $stable(tc_pulse_out[0])) else $error("done not held");
  AST_DONE_OUT: assert property (stat[0].done && $past(stat[0].done)
    |-> o_on) else $error("done without output");
  // Only the triggered modes: in gated modes a gate drop legally stretches
  // the pulse, so a fixed width holds there only while the gate stays on.
  AST_WIDTH: assert property (cfg[0].mode >= 4'h5 && clk_en
    && cfg[0].mode <= 4'h7 && cfg[0].pulse_width == 32'h0000_0004
    && !cfg[0].ext_clk_sel
    && $stable(cfg[0]) && $rose(o_on) |-> o_on [*4] ##1 !o_on)
    else $error("pulse width");
endmodule // general_timer_counter_chk

bind general_timer_counter_top general_timer_counter_chk u_chk (.clock(clock), .srst(srst), .clk_en(clk_en),
  .cfg(cfg), .sw_start(sw_start), .sw_reset(sw_reset),
  .tc_gate_in(tc_gate_in), .tc_pulse_out(tc_pulse_out), .stat(stat));

// File: bench/general_timer_counter_pin_src.sv
`timescale 1ns/1ps
// External count clock; it stands low between bursts, as a real source may.
module general_timer_counter_pin_src (
  // Count clock to all three sets.
  output logic [2:0] tc_clock_in
);
  initial tc_clock_in = 3'h0;
  // A 5 MHz rate stays under the 10 MHz external ceiling.
  // Called just after a core edge, so every pin edge also lands there.
  task automatic burst(input int n);
    repeat (n) begin
      #80 tc_clock_in = 3'h7;
      #120 tc_clock_in = 3'h0;
    end
  endtask
endmodule // general_timer_counter_pin_src

// File: bench/gp_timer_counter_modes_test.sv
`timescale 1ns/1ps
`include "general_timer_counter_map.svh"
module gp_timer_counter_modes_test;
  logic clock, srst, clk_en;
  logic [2:0] sw_start, sw_reset, tc_gate_in, tc_direction_in, tc_pulse_out;
  wire logic [2:0] tc_clock_in;
  general_timer_counter_pkg::general_timer_counter_cfg_t  c;
  general_timer_counter_pkg::general_timer_counter_cfg_t  cfg [3];
  general_timer_counter_pkg::general_timer_counter_stat_t stat [3];
  int miscompares = 0, num_checks = 0, np, nw;
  // All three sets get the same setup so set 2 can be compared with set 0.
  assign cfg = '{c, c, c};
  general_timer_counter_top dut (.clock(clock), .srst(srst), .clk_en(clk_en), .cfg(cfg),
    .sw_start(sw_start), .sw_reset(sw_reset), .tc_clock_in(tc_clock_in),
    .tc_gate_in(tc_gate_in), .tc_direction_in(tc_direction_in),
    .tc_pulse_out(tc_pulse_out), .stat(stat));
  general_timer_counter_pin_src src (.tc_clock_in(tc_clock_in));
  // Core clock at 25 MHz.
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Reset then start, each a one-cycle pulse, so both are taken cleanly.
  task automatic arm(input logic [3:0] m, input logic [31:0] w);
    c.mode = m;
    c.pulse_width = w;
    sw_reset = 3'h7;
    tick(1);
    sw_reset = 3'h0;
    sw_start = 3'h7;
    tick(1);
    sw_start = 3'h0;
  endtask
  // Counts active output pulses; the gate toggles every per cycles.
  task automatic run(input int n, input int per);
    logic p, on;
    p = 1'b0;
    np = 0;
    nw = 0;
    for (int i = 1; i <= n; i++) begin
      if (per != 0 && i % per == 0) tc_gate_in = ~tc_gate_in;
      tick(1);
      on = tc_pulse_out[0] ^ c.out_pol_low;
      np += int'(on && !p);
      nw += int'(on);
      p = on;
    end
  endtask
  task automatic t_ext_count;
    c = '0;
    c.ext_clk_sel = 1'b1;
    c.gate_pol_low = 1'b1;
    c.init_count = 32'h0000_0100;
    tc_gate_in = 3'h0;
    tc_direction_in = 3'h7;
    sw_reset = 3'h7;
    tick(1);
    sw_reset = 3'h0;
    tick(5);
    check("idle", stat[0].count, 32'h0000_0100);
    arm(4'h1, 32'h0000_0004);
    check("load", stat[0].count, 32'h0000_0100);
    src.burst(6);
    tick(6);
    check("up", stat[0].count, 32'h0000_0106);
    // Clock polarity flips only under a reset, so no false edge counts.
    tc_direction_in = 3'h0;
    c.clk_pol_low = 1'b1;
    arm(4'h1, 32'h0000_0004);
    src.burst(6);
    tick(6);
    check("down", stat[0].count, 32'h0000_00FA);
    tc_gate_in = 3'h7;
    src.burst(4);
    tick(6);
    check("gated", stat[0].count, 32'h0000_00FA);
    check("set2", stat[2].count, 32'h0000_00FA);
  endtask
  // Internal timebase, software direction down, then a clock-enable freeze.
  task automatic t_int_count;
    c = '0;
    c.sw_dir_sel = 1'b1;
    c.init_count = 32'h0000_0010;
    tc_gate_in = 3'h7;
    arm(4'h1, 32'h0000_0004);
    check("run", {stat[2].running, stat[1].running, stat[0].running},
          3'h7);
    tick(8);
    check("int", stat[0].count, 32'h0000_0008);
    check("set1", stat[1].count, 32'h0000_0008);
    clk_en = 1'b0;
    tick(5);
    check("freeze", stat[0].count, 32'h0000_0008);
    clk_en = 1'b1;
    tick(2);
    check("resume", stat[0].count, 32'h0000_0006);
  endtask
  // Same gate wave: period 30 cycles, high time 20 cycles.
  task automatic t_measure(input logic [3:0] m, input int exp);
    logic [31:0] k;
    c = '0;
    c.sw_dir_sel = 1'b1;
    c.sw_dir_up = 1'b1;
    tc_gate_in = 3'h0;
    arm(m, 32'h0000_0004);
    run(40, 20);
    run(50, 10);
    k = stat[0].count;
    check("done", stat[0].done, 1);
    check("out", tc_pulse_out, 3'h7);
    check("cnt", k >= exp - 1 && k <= exp + 1, 1);
    tick(20);
    check("frozen", stat[0].count, k);
  endtask
  task automatic t_pulses;
    for (int pol = 0; pol < 2; pol++) begin
      c.pulse_delay = 32'h0000_0002;
      c.out_pol_low = pol[0];
      tc_gate_in = 3'h0;
      arm(4'h4, 32'h0000_0004);
      run(20, 0);
      check("paused", np, 0);
      tc_gate_in = 3'h7;
      run(40, 0);
      check("single", np, 1);
      check("width", nw, 4);
    end
    for (int m = 5; m < 8; m++) begin
      tc_gate_in = 3'h0;
      arm(m[3:0], 32'h0000_0004);
      run(90, 15);
      if (m == 5) check("trig", np, 1);
      if (m == 6) check("retrig", np, 3);
      if (m == 7) check("train", np > 4, 1);
    end
    tc_gate_in = 3'h7;
    arm(4'h8, 32'h0000_0004);
    run(60, 0);
    check("cont", np > 2, 1);
    tc_gate_in = 3'h0;
    run(6, 0);
    run(40, 0);
    check("halt", nw == 0 || nw == 40, 1);
  endtask
  // Watchdog: the whole run needs well under 3,000 cycles.
  initial begin
    #200_000;
    miscompares++;
    finish_test();
  end
  initial begin
    c = '0;
    srst = 1'b1;
    clk_en = 1'b1;
    sw_start = 3'h0;
    sw_reset = 3'h0;
    tc_gate_in = 3'h0;
    tc_direction_in = 3'h7;
    tick(10);
    srst = 1'b0;
    t_ext_count();
    t_int_count();
    t_measure(4'h2, 30);
    t_measure(4'h3, 20);
    t_pulses();
    finish_test();
  end
endmodule // gp_timer_counter_modes_test
